// ==== logic/rpc_ctrl.sv ====
/*
 * Reset and low-power state controller for a two-core processor.
 * Assumes one 40 MHz clock, a synchronous active-high power-on reset, and
 * request strobes from on-chip sources that are already in this clock domain.
 */
// Summary of operation
// - Deep sleep stops both core clocks and synchronous peripheral clocks.
// - Deep sleep blocks asynchronous peripherals from internal and external memory.
// - Hibernate removes clocks and drops regulator wake to cut core voltage.
// - Hibernate three-states external pins except those with other behaviour.
// - During reset, affected registers take defaults and units stay idle.
// - After system reset only core 0 is released to boot.
// - After a single-core reset only that core is released.
// - Hardware reset clears everything, including reset history.
// - System reset clears everything except the reset control unit.
// - Core reset touches only its core; software keeps that core quiet.
// - Hardware reset comes from the low reset pin.
// - System reset comes from software, hibernate, event, trigger or emulator.
// - Single-core reset is started only by software.
// - Wake output is high for power-up, low for shutdown.
// - Reset pin in hibernate raises wake and then starts boot.
// - Core power on except hibernate; PLL off in sleep and hibernate.
`default_nettype none
module rpc_ctrl
    import rpc_pkg::*;
#(
    parameter int unsigned PWR_UP_CYC = `RPC_PWR_UP_CYC,
    parameter logic [7:0] RST_HOLD = `RPC_RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // External pins
    input wire logic hw_reset_n_in,
    output logic regulator_wake_out,
    output logic pin_oe_allow,
    // Reset requests, one-cycle strobes from on-chip logic
    input wire logic sw_sys_reset_req,
    input wire logic sec_reset_req,
    input wire logic tru_reset_req,
    input wire logic emu_reset_req,
    input wire logic [1:0] sw_core_reset_req,
    // Power-mode request
    input wire logic mode_req_valid,
    input wire logic [1:0] mode_req,
    input wire logic wake_event,
    // Clock and access control
    output logic core_clk_en,
    output logic sync_periph_clk_en,
    output logic async_access_en,
    output logic pll_en,
    // Resets and boot release
    output logic sys_reset,
    output logic [1:0] core_reset,
    output logic [1:0] core_boot_en,
    output logic rcu_reset,
    // Reset history
    output logic [2:0] reset_cause
);
    rpc_state_t state_q;
    logic hw_rst_n_s;
    logic hw_rst_act;
    logic hw_rst_pulse;
    logic hw_req;
    logic sys_req;
    logic sys_act;
    logic sys_act_q;
    logic hib_sys_req;
    logic [1:0] core_act;
    logic [1:0] core_act_q;
    logic [15:0] wake_cnt_q;

    rpc_sync #(.RST_VAL(1'b1)) u_hw_sync (
        .clk(core_clk),
        .reset(reset),
        .d(hw_reset_n_in),
        .q(hw_rst_n_s)
    );

    // pin or hibernate exit
    // Leaving hibernate reloads the hardware stretcher as well. The boot that follows is then
    // a full hardware reset, even if the pin was released before the regulator came up.
    assign hw_req = reset || !hw_rst_n_s || hib_sys_req;
    assign sys_req = sw_sys_reset_req || sec_reset_req || tru_reset_req ||
                     emu_reset_req || hib_sys_req || hw_req;

    rpc_stretch #(.HOLD(RST_HOLD)) u_hw_str (
        .clk(core_clk),
        .reset(1'b0),
        .req(hw_req),
        .active(hw_rst_act)
    );
    rpc_stretch #(.HOLD(RST_HOLD)) u_sys_str (
        .clk(core_clk),
        .reset(1'b0),
        .req(sys_req),
        .active(sys_act)
    );

    for (genvar i = 0; i < 2; i++) begin : g_core
        rpc_stretch #(.HOLD(RST_HOLD)) u_core_str (
            .clk(core_clk),
            .reset(1'b0),
            .req(sw_core_reset_req[i]),
            .active(core_act[i])
        );
    end

    assign hw_rst_pulse = hw_rst_act;

    // Power-mode state machine.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= RPC_ST_RESET;
            wake_cnt_q <= 16'h0000;
            hib_sys_req <= 1'b0;
        end else begin
            hib_sys_req <= 1'b0;
            case (state_q)
                RPC_ST_RESET: begin
                    // The request raised on leaving hibernate reaches the stretchers one
                    // cycle late, so it must also hold the machine here, or clocks restart
                    // while the system is still in reset.
                    if (!sys_act && !hib_sys_req) begin
                        state_q <= RPC_ST_RUN;
                    end
                end
                RPC_ST_RUN: begin
                    if (mode_req_valid && mode_req == `RPC_MODE_DEEP_SLEEP) begin
                        state_q <= RPC_ST_SLEEP;
                    end else if (mode_req_valid && mode_req == `RPC_MODE_HIBERNATE) begin
                        state_q <= RPC_ST_HIBER;
                    end
                end
                RPC_ST_SLEEP: begin
                    if (wake_event) begin
                        state_q <= RPC_ST_RUN;
                    end
                end
                RPC_ST_HIBER: begin
                    if (!hw_rst_n_s) begin
                        state_q <= RPC_ST_WAKE;
                        wake_cnt_q <= PWR_UP_CYC[15:0];
                    end
                end
                RPC_ST_WAKE: begin
                    if (wake_cnt_q == 16'h0000) begin
                        state_q <= RPC_ST_RESET;
                        hib_sys_req <= 1'b1;
                    end else begin
                        wake_cnt_q <= wake_cnt_q - 16'h0001;
                    end
                end
                default: state_q <= RPC_ST_RESET;
            endcase
            if (!hw_rst_n_s && state_q != RPC_ST_HIBER && state_q != RPC_ST_WAKE) begin
                state_q <= RPC_ST_RESET;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_clk_en <= 1'b0;
            sync_periph_clk_en <= 1'b0;
            async_access_en <= 1'b0;
            pll_en <= 1'b0;
        end else begin
            core_clk_en <= (state_q == RPC_ST_RUN);
            sync_periph_clk_en <= (state_q == RPC_ST_RUN);
            async_access_en <= (state_q == RPC_ST_RUN);
            pll_en <= (state_q == RPC_ST_RUN) || (state_q == RPC_ST_RESET);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            regulator_wake_out <= 1'b1;
            pin_oe_allow <= 1'b1;
        end else begin
            regulator_wake_out <= (state_q != RPC_ST_HIBER);
            pin_oe_allow <= (state_q != RPC_ST_HIBER) && (state_q != RPC_ST_WAKE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sys_reset <= 1'b1;
            rcu_reset <= 1'b1;
            core_reset <= 2'h3;
            core_boot_en <= 2'h0;
            sys_act_q <= 1'b1;
            core_act_q <= 2'h0;
        end else begin
            sys_act_q <= sys_act;
            core_act_q <= core_act;
            sys_reset <= sys_act;
            rcu_reset <= hw_rst_pulse;
            core_reset <= {2{sys_act}} | core_act;
            if (sys_act) begin
                core_boot_en <= 2'h0;
            end else if (sys_act_q) begin
                // core 0 only after system reset
                core_boot_en <= 2'h1;
            end else begin
                for (int i = 0; i < 2; i++) begin
                    if (core_act[i]) begin
                        core_boot_en[i] <= 1'b0;
                    end else if (core_act_q[i]) begin
                        core_boot_en[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Sticky reset cause: bit0 hardware, bit1 system, bit2 core.
    always_ff @(posedge core_clk) begin
        if (hw_rst_pulse) begin
            reset_cause <= 3'h1;
        end else begin
            if (sys_req) begin
                reset_cause[1] <= 1'b1;
            end
            if (|sw_core_reset_req) begin
                reset_cause[2] <= 1'b1;
            end
        end
    end

    a_wake_low_hib: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_HIBER |=> !regulator_wake_out)
        else $error("wake output not low in hibernate");
    a_wake_on_pin: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_HIBER && !hw_rst_n_s |=> ##1 regulator_wake_out)
        else $error("wake not raised after reset pin");
    a_sleep_clk_off: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_SLEEP |=> !core_clk_en && !sync_periph_clk_en)
        else $error("clocks running in deep sleep");
    a_async_fenced: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_SLEEP |=> !async_access_en)
        else $error("async access in deep sleep");
    a_pins_float: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_HIBER |=> !pin_oe_allow)
        else $error("pins driven in hibernate");
    a_pll_off: assert property (@(posedge core_clk) disable iff (reset)
        state_q == RPC_ST_SLEEP || state_q == RPC_ST_HIBER |=> !pll_en)
        else $error("PLL on in low-power mode");
    sequence s_sys_exit;
        sys_act_q && !sys_act;
    endsequence
    a_boot_core0: assert property (@(posedge core_clk) disable iff (reset)
        s_sys_exit |=> core_boot_en == 2'h1)
        else $error("wrong boot release after system reset");
    a_cores_held: assert property (@(posedge core_clk) disable iff (reset)
        sys_act |=> core_reset == 2'h3 && sys_reset && core_boot_en == 2'h0)
        else $error("cores not held during system reset");
    a_sw_sys_rst: assert property (@(posedge core_clk) disable iff (reset)
        sw_sys_reset_req |=> ##1 sys_reset [*8])
        else $error("software request gave no system reset");
    a_hib_exit_hw: assert property (@(posedge core_clk) disable iff (reset)
        hib_sys_req |=> hw_rst_act ##1 rcu_reset && reset_cause == 3'h1)
        else $error("hibernate exit did not act as hardware reset");
    a_rcu_kept: assert property (@(posedge core_clk) disable iff (reset)
        sw_sys_reset_req && !hw_rst_act && hw_rst_n_s |=> !rcu_reset)
        else $error("reset unit cleared by system reset");
endmodule // rpc_ctrl
`default_nettype wire

// ==== logic/rpc_defs.svh ====
/*
 * Constants for the reset and power-state controller: stretch counts and
 * power-mode encodings.
 * Assumes inclusion through the package file only.
 */
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

// Cycles a reset is stretched after its source goes away (40 MHz clock).
`define RPC_RST_HOLD_CYC 8'h10
// Cycles the regulator is given after wake is raised before boot begins.
`define RPC_PWR_UP_CYC 16'h0100
// Power-mode request encodings.
`define RPC_MODE_FULL_ON 2'h0
`define RPC_MODE_ACTIVE 2'h1
`define RPC_MODE_DEEP_SLEEP 2'h2
`define RPC_MODE_HIBERNATE 2'h3

`endif

// ==== logic/rpc_pkg.sv ====
/*
 * Types shared by the reset and power-state controller.
 * Assumes the constants header sits beside it.
 */
`default_nettype none
`include "rpc_defs.svh"
package rpc_pkg;
    typedef enum logic [4:0] {
        RPC_ST_RESET = 5'h01,
        RPC_ST_RUN = 5'h02,
        RPC_ST_SLEEP = 5'h04,
        RPC_ST_HIBER = 5'h08,
        RPC_ST_WAKE = 5'h10
    } rpc_state_t;
endpackage
`default_nettype wire

// ==== logic/rpc_sync.sv ====
/*
 * Two-flop synchroniser for one level.
 * Assumes the input is asynchronous to clk.
 */
`default_nettype none
module rpc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Level
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // rpc_sync

// ==== logic/rpc_stretch.sv ====
/*
 * Reset stretcher: holds its output for HOLD cycles after the request ends.
 * Assumes a synchronous request input, a one-clock strobe or a longer level.
 */
`default_nettype none
module rpc_stretch #(
    parameter logic [7:0] HOLD = 8'h10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request and stretched reset
    input wire logic req,
    output logic active
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk) begin
        if (reset || req) begin
            cnt_q <= HOLD;
            active <= 1'b1;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            active <= 1'b1;
        end else begin
            active <= 1'b0;
        end
    end
endmodule // rpc_stretch

// ==== dv/rpc_reg_model.sv ====
/*
 * Behavioural model of the external core regulator and reset source.
 * Assumes the bench asks for the reset pin through pull_req on core_clk.
 */
`default_nettype none
module rpc_reg_model #(
    parameter int RAMP = 6
) (
    // Clock
    input wire logic core_clk,
    // Device side
    input wire logic regulator_wake_out,
    output logic hw_reset_n_in,
    // Bench side
    input wire logic pull_req,
    output logic pwr_good
);
    timeunit 1ns;
    timeprecision 1ps;
    int ramp_q = 0;
    // high powers up.
    // The rail drops as soon as wake goes low, so a late wake shows as lost power.
    always_ff @(posedge core_clk) begin
        if (!regulator_wake_out) begin
            ramp_q <= 0;
        end else if (ramp_q < RAMP) begin
            ramp_q <= ramp_q + 1;
        end
    end
    assign pwr_good = (ramp_q == RAMP);
    // active-low pin.
    // The pin has a pull-up, so it reads high whenever the source lets go.
    assign hw_reset_n_in = !pull_req;
endmodule // rpc_reg_model
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 * Self-checking bench for the reset and power-state controller.
 * Assumes the regulator model beside it and shortened stretch counts.
 */
`default_nettype none
module testbench;
    import rpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [14:0] val; logic [14:0] msk;} rpc_note_t;
    logic core_clk = 1'b0, reset = 1'b1, hw_reset_n_in, regulator_wake_out, pin_oe_allow;
    logic sw_sys_reset_req = 1'b0, sec_reset_req = 1'b0, tru_reset_req = 1'b0;
    logic emu_reset_req = 1'b0, mode_req_valid = 1'b0, wake_event = 1'b0, pull_req = 1'b0;
    logic [1:0] sw_core_reset_req = 2'b00, mode_req = 2'b00, core_reset, core_boot_en;
    logic core_clk_en, sync_periph_clk_en, async_access_en, pll_en, sys_reset, rcu_reset;
    logic pwr_good;
    logic [2:0] reset_cause;
    logic [14:0] obs;
    rpc_note_t notes[$];
    event snap;
    int fail_count = 0, checks = 0;
    logic [31:0] seed = 32'hbc93;
    localparam logic [14:0] M_RUN = 15'h7ffc;
    always #12.5 core_clk = ~core_clk;
    assign obs = {core_boot_en, reset_cause, core_clk_en, sync_periph_clk_en, async_access_en,
                  pll_en, regulator_wake_out, pin_oe_allow, sys_reset, rcu_reset, core_reset};
    rpc_ctrl #(.PWR_UP_CYC(4), .RST_HOLD(8'h08)) i_rpc_ctrl (
        .core_clk(core_clk), .reset(reset), .hw_reset_n_in(hw_reset_n_in),
        .regulator_wake_out(regulator_wake_out), .pin_oe_allow(pin_oe_allow),
        .sw_sys_reset_req(sw_sys_reset_req), .sec_reset_req(sec_reset_req),
        .tru_reset_req(tru_reset_req), .emu_reset_req(emu_reset_req),
        .sw_core_reset_req(sw_core_reset_req), .mode_req_valid(mode_req_valid),
        .mode_req(mode_req), .wake_event(wake_event), .core_clk_en(core_clk_en),
        .sync_periph_clk_en(sync_periph_clk_en), .async_access_en(async_access_en),
        .pll_en(pll_en), .sys_reset(sys_reset), .core_reset(core_reset),
        .core_boot_en(core_boot_en), .rcu_reset(rcu_reset), .reset_cause(reset_cause));
    rpc_reg_model i_rpc_reg_model (.core_clk(core_clk), .regulator_wake_out(regulator_wake_out),
        .hw_reset_n_in(hw_reset_n_in), .pull_req(pull_req), .pwr_good(pwr_good));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [14:0] seen, input logic [14:0] want);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic expect_obs(input logic [14:0] val, input logic [14:0] msk);
        notes.push_back('{val: val, msk: msk});
        -> snap;
        #1;
    endtask
    // Outputs are compared a settled half cycle after the edge that moved them.
    task automatic wait_for(input logic [14:0] val, input logic [14:0] msk, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(negedge core_clk);
            if ((obs & msk) === val) return;
        end
        fail_count++;
        $display("CHECK FAILED at %0t: wait for %h timed out", $time, val);
        wrap_up();
    endtask
    task automatic pulse(input int k);
        seed = xorshift(seed);
        repeat (1 + seed[1:0]) @(posedge core_clk);
        case (k)
            0: sw_sys_reset_req <= 1'b1;
            1: sec_reset_req <= 1'b1;
            2: tru_reset_req <= 1'b1;
            3: emu_reset_req <= 1'b1;
            4: sw_core_reset_req <= 2'b01;
            5: sw_core_reset_req <= 2'b10;
            6: wake_event <= 1'b1;
            default: mode_req_valid <= 1'b1;
        endcase
        mode_req <= k[1:0];
        @(posedge core_clk);
        {sw_sys_reset_req, sec_reset_req, tru_reset_req, emu_reset_req} <= 4'h0;
        {sw_core_reset_req, wake_event, mode_req_valid} <= 4'h0;
    endtask
    // The oldest note is always the one the driver just announced.
    initial begin
        rpc_note_t n;
        forever begin
            @(snap);
            n = notes.pop_front();
            check(obs & n.msk, n.val);
        end
    end
    initial begin
        int k;
        int base;
        logic [2:0] cause;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        wait_for(15'h2200, 15'h6200, 100);
        expect_obs({2'b01, 3'b001, 4'hf, 4'b1100, 2'b00}, M_RUN);
        $display("test power-on reset done");
        seed = xorshift(seed);
        base = seed[1:0];
        for (int j = 0; j < 4; j++) begin
            k = (j + base) % 4;
            pulse(k);
            wait_for(15'h0008, 15'h0008, 10);
            // system reset spares the reset control unit.
            expect_obs({2'b00, 3'b000, 4'h0, 4'b0010, 2'b00}, 15'h600c);
            wait_for(15'h2000, 15'h6008, 60);
            expect_obs({2'b01, 3'b011, 4'hf, 4'b1100, 2'b00}, M_RUN);
        end
        $display("test system reset sources done");
        cause = 3'b111;
        for (int c = 0; c < 2; c++) begin
            pulse(5 - c);
            wait_for({13'h0, 2'(2 >> c)}, {13'h0, 2'(2 >> c)}, 10);
            // only the named core is held.
            expect_obs({10'h0, 1'b0, 2'b00, 2'(2 >> c)}, 15'h000f);
            wait_for({2'(2 >> c), 13'h0}, {2'(2 >> c), 11'h0, 2'(2 >> c)}, 60);
            expect_obs({2'(2 >> c), cause, 10'h0}, {2'(2 >> c), 3'b111, 10'h0});
        end
        $display("test core reset done");
        pulse(10);
        wait_for(15'h0000, 15'h0200, 10);
        // clocks stop and power stays on.
        expect_obs({5'h0, 4'h0, 2'b11, 4'h0}, 15'h03f8);
        pulse(6);
        wait_for(15'h03c0, 15'h03c0, 20);
        expect_obs({5'h0, 4'hf, 2'b11, 4'h0}, 15'h03f8);
        $display("test deep sleep done");
        pulse(7);
        wait_for(15'h0000, 15'h0020, 10);
        expect_obs({5'h0, 4'h0, 2'b00, 4'h0}, 15'h03f0);
        @(posedge core_clk);
        pull_req <= 1'b1;
        wait_for(15'h0020, 15'h0020, 20);
        // Wake is up, pins still float and the reset unit is held by the pin.
        expect_obs(15'h0424, 15'h1c34);
        for (int w = 0; w < 50 && pwr_good !== 1'b1; w++) @(posedge core_clk);
        if (pwr_good !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: regulator never came up", $time);
            wrap_up();
        end
        pull_req <= 1'b0;
        wait_for(15'h2200, 15'h6208, 400);
        expect_obs({2'b01, 3'b001, 4'hf, 4'b1100, 2'b00}, M_RUN);
        $display("test hibernate exit done");
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
